// >>> hdl/tpc_debounce.sv
`timescale 1ns/1ps
// one button: two-flop synchroniser, hold filter, press pulse
module tpc_debounce #(
  parameter int unsigned HOLD_CYC = tpc_pkg::DEBOUNCE_CYC
)(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // raw button and filtered press
  input  wire logic btn_i,
  output logic      press_o
);
  localparam int CW = (HOLD_CYC > 1) ? $clog2(HOLD_CYC + 1) : 1;

  logic          sync1_q;   // first synchroniser stage, read only by sync2_q
  logic          sync2_q;   // synchronised level
  logic          level_q;   // debounced level
  logic [CW-1:0] cnt_q;     // stability counter
  logic          press_q;   // registered press pulse

  wire           differ  = (sync2_q != level_q);
  wire           settled = (cnt_q == CW'(HOLD_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // synchronise and filter; a press fires once on the rising debounced edge
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q   <= '0;
      press_q <= 1'b0;
    end
    else
    begin
      sync1_q <= btn_i;
      sync2_q <= sync1_q;
      press_q <= 1'b0;
      if (!differ)
        cnt_q <= '0;
      else if (settled)
      begin
        cnt_q   <= '0;
        level_q <= sync2_q;
        press_q <= sync2_q;
      end
      else
        cnt_q <= cnt_q + CW'(1);
    end
  end

  assign press_o = press_q;
endmodule // tpc_debounce

// >>> hdl/tpc_panel.sv
`timescale 1ns/1ps
// Behaviour
// - threaded, unloaded: load button starts load
// - loaded: load button rewinds to start marker
// - loaded at start: unload winds tape off
// - loaded past start: unload only rewinds
// - threaded, unloaded: unload does slow unload
// - loaded: on-line button goes on-line, lamp lit
// - on-line during load remembered until loaded
// - on-line: ignore all buttons but reset
// - no write ring: lock lamp, block writes
// - dense lamp while host selects group coding
// - reset: off-line, stop motion, clear errors
// - reset aborts motion, clears fault, diagnostic
// - fault lamp in fault or diagnostic state
// - fault latched: only reset accepted
// - display unit, error code, or test number
// - test when threaded: diagnostic mode, lamp held
// - step increments displayed test number
// - run starts displayed test
// - interface button: first transmit, second clear
// - clear fail keeps lamp, unavailable; else restore
// - interface fault: display unit number, test number in diagnostic
// - port buttons select; port live when on-line
module tpc_panel #(
  parameter int unsigned DEBOUNCE_CYC = tpc_pkg::DEBOUNCE_CYC
)(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // operator pushbuttons, raw and active high
  input  wire logic        load_button_i,
  input  wire logic        unload_button_i,
  input  wire logic        online_button_i,
  input  wire logic        reset_button_i,
  input  wire logic        test_button_i,
  input  wire logic        step_button_i,
  input  wire logic        run_test_button_i,
  input  wire logic        interface_error_button_i,
  input  wire logic        port_a_button_i,
  input  wire logic        port_b_button_i,
  // transport status, same clock domain
  input  wire logic        power_good_i,
  input  wire logic        tape_threaded_i,
  input  wire logic        tape_start_marker_i,
  input  wire logic        motion_done_i,
  input  wire logic        write_ring_i,
  input  wire logic        dense_select_i,
  input  wire logic        fault_i,
  input  wire logic [11:0] fault_code_i,
  input  wire logic [11:0] unit_number_i,
  input  wire logic        iface_fault_i,
  input  wire logic        iface_clear_done_i,
  input  wire logic        iface_clear_ok_i,
  // motion and controller commands
  output logic [2:0]       motion_cmd_o,
  output logic             motion_start_o,
  output logic             error_clear_o,
  output logic             test_start_o,
  output logic [11:0]      test_number_o,
  output logic             iface_transmit_o,
  output logic             iface_clear_o,
  output logic             host_available_o,
  output logic             write_allowed_o,
  output logic             port_a_live_o,
  output logic             port_b_live_o,
  // lamps and display
  output logic             online_lamp_o,
  output logic             tape_start_marker_lamp_o,
  output logic             write_lock_lamp_o,
  output logic             dense_recording_lamp_o,
  output logic             fault_lamp_o,
  output logic             diagnostic_lamp_o,
  output logic             interface_error_button_lamp_o,
  output logic             port_a_lamp_o,
  output logic             port_b_lamp_o,
  output logic [11:0]      display_o
);
  ////////////////////////////////////////////////////////////////////////////
  // button conditioning

  logic [tpc_pkg::BTN_COUNT-1:0] raw_btn;     // raw buttons gathered
  logic [tpc_pkg::BTN_COUNT-1:0] press;       // one-cycle press pulses

  assign raw_btn[tpc_pkg::BTN_LOAD]   = load_button_i;
  assign raw_btn[tpc_pkg::BTN_UNLOAD] = unload_button_i;
  assign raw_btn[tpc_pkg::BTN_ONLINE] = online_button_i;
  assign raw_btn[tpc_pkg::BTN_RESET]  = reset_button_i;
  assign raw_btn[tpc_pkg::BTN_TEST]   = test_button_i;
  assign raw_btn[tpc_pkg::BTN_STEP]   = step_button_i;
  assign raw_btn[tpc_pkg::BTN_RUN]    = run_test_button_i;
  assign raw_btn[tpc_pkg::BTN_IFERR]  = interface_error_button_i;
  assign raw_btn[tpc_pkg::BTN_PORTA]  = port_a_button_i;
  assign raw_btn[tpc_pkg::BTN_PORTB]  = port_b_button_i;

  // one filter per button
  genvar gi;
  generate
    for (gi = 0; gi < tpc_pkg::BTN_COUNT; gi++)
    begin : g_btn
      tpc_debounce #(
        .HOLD_CYC (DEBOUNCE_CYC)
      ) u_deb (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .btn_i     (raw_btn[gi]),
        .press_o   (press[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state and registers

  tpc_pkg::tpc_state_t state_q;       // tape condition
  tpc_pkg::tpc_state_t state_d;
  logic        online_pend_q;         // on-line asked during load
  logic        online_pend_d;
  logic        fault_q;               // latched fault, cleared by reset button
  logic [11:0] err_code_q;            // latched error code
  logic [11:0] test_num_q;            // diagnostic test number
  logic        iface_armed_q;         // first interface press seen
  logic        iface_wait_q;          // clear attempt outstanding
  logic        iface_unavail_q;       // clear failed, host cut off
  logic        port_a_q;              // port selections
  logic        port_b_q;
  logic [2:0]  mcmd_q;                // motion command register
  logic [2:0]  mcmd_d;
  logic        mstart_q;              // motion start pulse
  logic        mstart_d;
  logic        err_clr_q;             // error clear pulse
  logic        test_start_q;          // test start pulse
  logic        iface_tx_q;            // transmit pulse
  logic        iface_clr_q;           // clear attempt pulse
  logic [11:0] disp_q;                // display register

  ////////////////////////////////////////////////////////////////////////////
  // qualified presses

  // reset is always honoured; fault or on-line lock out the rest
  wire rst_press    = press[tpc_pkg::BTN_RESET];
  wire fault_now    = fault_q | fault_i;
  wire panel_locked = fault_now | (state_q == tpc_pkg::ST_ONLINE) | (state_q == tpc_pkg::ST_DIAG);
  wire op_ok        = power_good_i & !panel_locked & !rst_press;
  wire at_idle      = (state_q == tpc_pkg::ST_IDLE);
  wire threaded_ok  = at_idle & tape_threaded_i;
  wire loaded       = (state_q == tpc_pkg::ST_LOADED);

  wire p_load       = op_ok & press[tpc_pkg::BTN_LOAD];
  wire p_unload     = op_ok & press[tpc_pkg::BTN_UNLOAD];
  wire p_online     = op_ok & press[tpc_pkg::BTN_ONLINE];
  wire p_test       = op_ok & press[tpc_pkg::BTN_TEST];
  // diagnostic-mode buttons: fault from outside still locks them
  wire diag_ok      = (state_q == tpc_pkg::ST_DIAG) & !fault_now & !rst_press;
  wire p_step       = diag_ok & press[tpc_pkg::BTN_STEP];
  wire p_run        = diag_ok & press[tpc_pkg::BTN_RUN];
  // interface and port buttons are panel buttons too
  wire side_ok      = !fault_now & (state_q != tpc_pkg::ST_ONLINE) & !rst_press;
  wire p_iferr      = side_ok & iface_fault_i & press[tpc_pkg::BTN_IFERR];
  wire p_port_a     = side_ok & press[tpc_pkg::BTN_PORTA];
  wire p_port_b     = side_ok & press[tpc_pkg::BTN_PORTB];

  ////////////////////////////////////////////////////////////////////////////
  // next state decode
  always_comb
  begin
    state_d       = state_q;
    online_pend_d = online_pend_q;
    mcmd_d        = mcmd_q;
    mstart_d      = 1'b0;
    if (rst_press)
    begin
      // abort motion, drop on-line and diagnostic
      online_pend_d = 1'b0;
      mcmd_d        = tpc_pkg::MOT_STOP;
      mstart_d      = 1'b1;
      state_d       = (state_q == tpc_pkg::ST_IDLE || state_q == tpc_pkg::ST_DIAG ||
                       state_q == tpc_pkg::ST_LOADING || state_q == tpc_pkg::ST_UNLOAD)
                      ? tpc_pkg::ST_IDLE : tpc_pkg::ST_LOADED;
    end
    else
    begin
      unique case (state_q)
        tpc_pkg::ST_IDLE:
        begin
          if (p_load && threaded_ok)
          begin
            state_d  = tpc_pkg::ST_LOADING;
            mcmd_d   = tpc_pkg::MOT_LOAD;
            mstart_d = 1'b1;
          end
          else if (p_unload && threaded_ok)
          begin
            state_d  = tpc_pkg::ST_UNLOAD;
            mcmd_d   = tpc_pkg::MOT_SLOW_UNLD;
            mstart_d = 1'b1;
          end
          else if (p_test && threaded_ok)
            state_d = tpc_pkg::ST_DIAG;
        end
        tpc_pkg::ST_LOADING:
        begin
          if (press[tpc_pkg::BTN_ONLINE] && !fault_now)
            online_pend_d = 1'b1;
          if (motion_done_i)
          begin
            state_d       = (online_pend_q || (press[tpc_pkg::BTN_ONLINE] && !fault_now))
                            ? tpc_pkg::ST_ONLINE : tpc_pkg::ST_LOADED;
            online_pend_d = 1'b0;
          end
        end
        tpc_pkg::ST_LOADED:
        begin
          if (p_load)
          begin
            state_d  = tpc_pkg::ST_REWIND;
            mcmd_d   = tpc_pkg::MOT_REWIND;
            mstart_d = 1'b1;
          end
          else if (p_unload && tape_start_marker_i)
          begin
            state_d  = tpc_pkg::ST_UNLOAD;
            mcmd_d   = tpc_pkg::MOT_UNLOAD;
            mstart_d = 1'b1;
          end
          else if (p_unload)
          begin
            state_d  = tpc_pkg::ST_REWIND;
            mcmd_d   = tpc_pkg::MOT_REWIND;
            mstart_d = 1'b1;
          end
          else if (p_online)
            state_d = tpc_pkg::ST_ONLINE;
        end
        tpc_pkg::ST_REWIND:
          if (motion_done_i)
            state_d = tpc_pkg::ST_LOADED;
        tpc_pkg::ST_UNLOAD:
          if (motion_done_i)
            state_d = tpc_pkg::ST_IDLE;
        tpc_pkg::ST_ONLINE:
          state_d = tpc_pkg::ST_ONLINE;
        tpc_pkg::ST_DIAG:
          state_d = tpc_pkg::ST_DIAG;
        default:
          state_d = tpc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and motion registers
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q       <= tpc_pkg::ST_IDLE;
      online_pend_q <= 1'b0;
      mcmd_q        <= tpc_pkg::MOT_NONE;
      mstart_q      <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      online_pend_q <= online_pend_d;
      mcmd_q        <= mcmd_d;
      mstart_q      <= mstart_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault latch and error code; a new fault wins over the reset press
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fault_q    <= 1'b0;
      err_code_q <= '0;
      err_clr_q  <= 1'b0;
    end
    else
    begin
      err_clr_q <= rst_press;
      if (fault_i)
      begin
        fault_q    <= 1'b1;
        err_code_q <= fault_code_i;
      end
      else if (rst_press)
        fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic test number and test start
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      test_num_q   <= tpc_pkg::TEST_NUM_RESET;
      test_start_q <= 1'b0;
    end
    else
    begin
      test_start_q <= p_run;
      if (rst_press || p_test)
        test_num_q <= tpc_pkg::TEST_NUM_RESET;
      else if (p_step)
        test_num_q <= (test_num_q == tpc_pkg::TEST_NUM_LAST)
                      ? tpc_pkg::TEST_NUM_RESET : bcd_inc(test_num_q);
    end
  end

  // three-digit decimal increment
  function automatic logic [11:0] bcd_inc(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (r[3:0] != 4'h9)
      r[3:0] = r[3:0] + 4'h1;
    else
    begin
      r[3:0] = 4'h0;
      if (r[7:4] != 4'h9)
        r[7:4] = r[7:4] + 4'h1;
      else
      begin
        r[7:4]  = 4'h0;
        r[11:8] = r[11:8] + 4'h1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // interface-error button: first press transmits, second clears
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      iface_armed_q   <= 1'b0;
      iface_wait_q    <= 1'b0;
      iface_unavail_q <= 1'b0;
      iface_tx_q      <= 1'b0;
      iface_clr_q     <= 1'b0;
    end
    else
    begin
      iface_tx_q  <= p_iferr & !iface_armed_q;
      iface_clr_q <= p_iferr & iface_armed_q & !iface_wait_q;
      if (p_iferr && !iface_armed_q)
        iface_armed_q <= 1'b1;
      else if (p_iferr && !iface_wait_q)
        iface_wait_q <= 1'b1;
      if (iface_wait_q && iface_clear_done_i)
      begin
        iface_wait_q    <= 1'b0;
        iface_armed_q   <= 1'b0;
        iface_unavail_q <= !iface_clear_ok_i;
      end
      else if (!iface_fault_i)
      begin
        iface_unavail_q <= 1'b0;
        iface_armed_q   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port selection, toggled by each port button
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      port_a_q <= 1'b0;
      port_b_q <= 1'b0;
    end
    else
    begin
      if (p_port_a)
        port_a_q <= !port_a_q;
      if (p_port_b)
        port_b_q <= !port_b_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display source; interface fault hides the error code
  wire show_test = (state_q == tpc_pkg::ST_DIAG) & !fault_q;
  wire show_err  = fault_q & !iface_fault_i;
  wire [11:0] disp_d = show_err  ? err_code_q :
                       show_test ? test_num_q : unit_number_i;

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      disp_q <= '0;
    else
      disp_q <= disp_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire is_online = (state_q == tpc_pkg::ST_ONLINE);

  assign motion_cmd_o                  = mcmd_q;
  assign motion_start_o                = mstart_q;
  assign error_clear_o                 = err_clr_q;
  assign test_start_o                  = test_start_q;
  assign test_number_o                 = test_num_q;
  assign iface_transmit_o              = iface_tx_q;
  assign iface_clear_o                 = iface_clr_q;
  assign host_available_o              = is_online & !iface_unavail_q;
  assign write_allowed_o               = write_ring_i;
  assign write_lock_lamp_o             = !write_ring_i;
  assign dense_recording_lamp_o        = dense_select_i;
  assign online_lamp_o                 = is_online;
  assign tape_start_marker_lamp_o      = tape_start_marker_i & (state_q != tpc_pkg::ST_IDLE);
  assign fault_lamp_o                  = fault_q | (state_q == tpc_pkg::ST_DIAG);
  assign diagnostic_lamp_o             = (state_q == tpc_pkg::ST_DIAG);
  assign interface_error_button_lamp_o = iface_fault_i | iface_unavail_q;
  assign port_a_lamp_o                 = port_a_q;
  assign port_b_lamp_o                 = port_b_q;
  assign port_a_live_o                 = is_online & port_a_q;
  assign port_b_live_o                 = is_online & port_b_q;
  assign display_o                     = disp_q;
endmodule // tpc_panel

// >>> inc/tpc_pkg.sv
package tpc_pkg;
  // tape condition as seen by the panel
  typedef enum logic [6:0]
  {
    ST_IDLE     = 7'b000_0001, // threaded or empty, not loaded
    ST_LOADING  = 7'b000_0010, // load in progress
    ST_LOADED   = 7'b000_0100, // loaded, off-line
    ST_REWIND   = 7'b000_1000, // rewinding to the start marker
    ST_UNLOAD   = 7'b001_0000, // unloading onto the supply reel
    ST_ONLINE   = 7'b010_0000, // on-line to the host
    ST_DIAG     = 7'b100_0000  // diagnostic/test mode
  } tpc_state_t;

  // motion command codes sent to the transport
  localparam logic [2:0] MOT_NONE      = 3'h0;
  localparam logic [2:0] MOT_LOAD      = 3'h1;
  localparam logic [2:0] MOT_REWIND    = 3'h2;
  localparam logic [2:0] MOT_UNLOAD    = 3'h3;
  localparam logic [2:0] MOT_SLOW_UNLD = 3'h4;
  localparam logic [2:0] MOT_STOP      = 3'h5;

  // debounce time and derived count at the 10 MHz system clock
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned DEBOUNCE_US    = 5000;
  localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

  // button indices
  localparam int BTN_LOAD   = 0;
  localparam int BTN_UNLOAD = 1;
  localparam int BTN_ONLINE = 2;
  localparam int BTN_RESET  = 3;
  localparam int BTN_TEST   = 4;
  localparam int BTN_STEP   = 5;
  localparam int BTN_RUN    = 6;
  localparam int BTN_IFERR  = 7;
  localparam int BTN_PORTA  = 8;
  localparam int BTN_PORTB  = 9;
  localparam int BTN_COUNT  = 10;

  // display source: unit number, error code, test number (12 bits, 3 digits)
  localparam logic [11:0] TEST_NUM_RESET = 12'h001;
  localparam logic [11:0] TEST_NUM_LAST  = 12'h999;
endpackage

// >>> verification/tape_panel_control_tb.sv
`timescale 1ns/1ps
module tape_panel_control_tb;
  logic clk_sys_i = 0, reset_i = 1, go = 0, busy, power_good_i = 1, tape_threaded_i = 1;
  logic tape_start_marker_i = 0, motion_done_i = 0, write_ring_i = 0, dense_select_i = 0;
  logic fault_i = 0, iface_fault_i = 0, iface_clear_done_i = 0, iface_clear_ok_i = 0;
  logic [3:0] which = 0;
  logic [9:0] btn;
  logic [11:0] fault_code_i = 0, unit_number_i = 12'h042, run_num = 0, test_number_o, display_o;
  logic load_button_i, unload_button_i, online_button_i, reset_button_i, test_button_i;
  logic step_button_i, run_test_button_i, interface_error_button_i, port_a_button_i, port_b_button_i;
  logic [2:0] motion_cmd_o;
  logic motion_start_o, error_clear_o, test_start_o, iface_transmit_o, iface_clear_o;
  logic host_available_o, write_allowed_o, port_a_live_o, port_b_live_o, online_lamp_o;
  logic tape_start_marker_lamp_o, write_lock_lamp_o, dense_recording_lamp_o, fault_lamp_o;
  logic diagnostic_lamp_o, interface_error_button_lamp_o, port_a_lamp_o, port_b_lamp_o;
  int n_mismatch = 0, checked = 0, cyc = 0, n_tx = 0, n_clr = 0;
  assign {port_b_button_i, port_a_button_i, interface_error_button_i, run_test_button_i, step_button_i,
          test_button_i, reset_button_i, online_button_i, unload_button_i, load_button_i} = btn;
  // short filter keeps each press to a few dozen cycles
  tpc_panel #(.DEBOUNCE_CYC(4)) dut (.*);
  tpc_operator op (.clk_sys_i(clk_sys_i), .go_i(go), .which_i(which), .button_o(btn), .busy_o(busy));
  always #50 clk_sys_i = ~clk_sys_i;
  task chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task press(input int i);
    go = 1;
    which = 4'(i);
    @(posedge clk_sys_i);
    #1 go = 0;
    for (int k = 0; k < 60 && busy; k++) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic strobe(ref logic s);
    s = 1;
    @(posedge clk_sys_i);
    #1 s = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task mv(input int i, input logic mk, input logic [2:0] e);
    tape_start_marker_i = mk;
    press(i);
    chk("motion", {9'h000, motion_cmd_o}, {9'h000, e});
    chk("marker", tape_start_marker_lamp_o, mk);
    strobe(motion_done_i);
  endtask
  // pulse tally and hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (iface_transmit_o === 1'b1) n_tx++;
    if (iface_clear_o === 1'b1) n_clr++;
    if (test_start_o === 1'b1) run_num = test_number_o;
    if (cyc == 6000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 reset_i = 0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("display", display_o, 12'h042);
    chk("wlock", write_lock_lamp_o, 1);
    write_ring_i = 1;
    dense_select_i = 1;
    @(posedge clk_sys_i);
    #1 chk("write", write_allowed_o, 1);
    chk("dense", dense_recording_lamp_o, 1);
    press(8);
    chk("port_a", port_a_lamp_o, 1);
    press(9);
    chk("port_b", port_b_lamp_o, 1);
    press(0);
    chk("motion", {9'h000, motion_cmd_o}, 12'h001);
    press(2);
    chk("online", online_lamp_o, 0);
    strobe(motion_done_i);
    chk("online", online_lamp_o, 1);
    chk("live", port_a_live_o, 1);
    press(4);
    chk("diag", diagnostic_lamp_o, 0);
    press(3);
    chk("online", online_lamp_o, 0);
    chk("stop", motion_cmd_o, 3'h5);
    $display("load and on-line done");
    mv(0, 0, 3'h2);
    mv(1, 0, 3'h2);
    mv(1, 1, 3'h3);
    mv(1, 0, 3'h4);
    $display("motion done");
    press(4);
    chk("diag", diagnostic_lamp_o, 1);
    chk("flamp", fault_lamp_o, 1);
    chk("display", display_o, 12'h001);
    press(5);
    chk("display", display_o, 12'h002);
    press(6);
    chk("run", run_num, 12'h002);
    press(3);
    chk("diag", diagnostic_lamp_o, 0);
    fault_code_i = 12'hE31;
    strobe(fault_i);
    chk("display", display_o, 12'hE31);
    press(0);
    chk("ignored", motion_cmd_o, 3'h5);
    press(3);
    chk("flamp", fault_lamp_o, 0);
    $display("diag and fault done");
    iface_fault_i = 1;
    strobe(fault_i);
    chk("display", display_o, 12'h042);
    press(3);
    press(7);
    chk("transmit", 12'(n_tx), 12'h001);
    press(7);
    chk("clear", 12'(n_clr), 12'h001);
    strobe(iface_clear_done_i);
    chk("iflamp", interface_error_button_lamp_o, 1);
    mv(0, 0, 3'h1);
    press(2);
    chk("online", online_lamp_o, 1);
    chk("avail", host_available_o, 0);
    chk("live_b", port_b_live_o, 1);
    iface_fault_i = 0;
    @(posedge clk_sys_i);
    #1 chk("avail", host_available_o, 1);
    chk("iflamp", interface_error_button_lamp_o, 0);
    $display("interface done");
    give_verdict;
  end
endmodule // tape_panel_control_tb

// >>> verification/tpc_operator.sv
`timescale 1ns/1ps
// operator: holds one button, then lets go
module tpc_operator #(
  parameter int HOLD = 12
)(
  // clock and request from the bench
  input  wire logic       clk_sys_i,
  input  wire logic       go_i,
  input  wire logic [3:0] which_i,
  // pushbuttons and busy status
  output logic      [9:0] button_o,
  output logic            busy_o
);
  int n;
  initial
  begin
    button_o = '0;
    busy_o   = 1'b0;
  end
  // held well past the filter so each press lands once
  always @(posedge clk_sys_i)
  begin
    if (go_i && !busy_o)
    begin
      button_o[which_i] <= 1'b1;
      busy_o            <= 1'b1;
      n                 <= 0;
    end
    else if (busy_o)
    begin
      n <= n + 1;
      if (n == HOLD) button_o <= '0;
      if (n == 2 * HOLD) busy_o <= 1'b0;
    end
  end
endmodule // tpc_operator

// >>> verification/tpc_panel_chk.sv
`timescale 1ns/1ps
// panel outputs against their causes
module tpc_panel_chk (
  // clock, reset and causes
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       write_ring_i,
  input wire logic       dense_select_i,
  input wire logic       fault_i,
  // watched outputs
  input wire logic [2:0] motion_cmd_o,
  input wire logic       motion_start_o,
  input wire logic       error_clear_o,
  input wire logic       test_start_o,
  input wire logic       host_available_o,
  input wire logic       port_a_live_o,
  input wire logic       port_b_live_o,
  input wire logic       online_lamp_o,
  input wire logic       write_lock_lamp_o,
  input wire logic       dense_recording_lamp_o,
  input wire logic       fault_lamp_o,
  input wire logic       diagnostic_lamp_o,
  input wire logic       port_a_lamp_o,
  input wire logic       port_b_lamp_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_lock_lamp: assert property (write_lock_lamp_o == !write_ring_i)
    else $error("lock lamp wrong");
  a_dense_lamp: assert property (dense_recording_lamp_o == dense_select_i)
    else $error("dense lamp wrong");
  a_online_quiet: assert property ($past(online_lamp_o) && motion_start_o |-> motion_cmd_o == 3'h5)
    else $error("motion while on-line");
  a_pulse_once: assert property (motion_start_o |=> !motion_start_o)
    else $error("start pulse too long");
  a_clear_stops: assert property (error_clear_o |-> motion_start_o && motion_cmd_o == 3'h5)
    else $error("clear without stop");
  a_fault_latch: assert property (fault_i |=> fault_lamp_o)
    else $error("fault lamp not lit");
  a_diag_fault: assert property (diagnostic_lamp_o |-> fault_lamp_o)
    else $error("diag without fault lamp");
  a_run_diag: assert property (test_start_o |-> diagnostic_lamp_o)
    else $error("test outside diag");
  a_port_a: assert property (port_a_live_o == (online_lamp_o && port_a_lamp_o))
    else $error("port a live wrong");
  a_port_b: assert property (port_b_live_o == (online_lamp_o && port_b_lamp_o))
    else $error("port b live wrong");
  a_avail_online: assert property (host_available_o |-> online_lamp_o)
    else $error("available off-line");
  c_load: cover property (motion_start_o && motion_cmd_o == 3'h1);
  c_test: cover property (test_start_o);
  c_live: cover property (port_a_live_o);
endmodule // tpc_panel_chk

bind tpc_panel tpc_panel_chk chk (.*);
